// ### hw/smc_crc8.sv
// parallel 8-bit checksum over the 32 leading bits of a frame
module smc_crc8 (
  smc_crc_if.calc bus
);
  always_comb begin
    logic [7:0] c;
    c = smc_pkg::CRC_INIT;
    for (int i = 31; i >= 0; i--) begin
      if (c[7] ^ bus.data[i]) begin
        c = {c[6:0], 1'b0} ^ smc_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    bus.crc = c;
  end
endmodule

// ### hw/smc_crc_if.sv
// carrier between the frame logic and a checksum calculator
interface smc_crc_if;
  logic [31:0] data;
  logic [7:0]  crc;
  modport calc (input data, output crc);
  modport user (output data, input crc);
endinterface

// ### hw/smc_pkg.sv
// constants shared by the switch monitor configuration logic
package smc_pkg;
  // ****************************************************************
  // frame layout
  // ****************************************************************
  localparam int          FRAME_BITS  = 40;
  localparam logic [5:0]  FRAME_LEN   = 6'h28;
  localparam logic [5:0]  CNT_MAX     = 6'h29;
  localparam int          HDR_MSB     = 39;
  localparam int          HDR_LSB     = 38;
  localparam int          WR_RD_BIT   = 37;
  localparam int          ADDR_MSB    = 36;
  localparam int          ADDR_LSB    = 32;
  localparam int          DATA_MSB    = 31;
  localparam int          DATA_LSB    = 8;
  localparam int          CRC_MSB     = 7;
  localparam logic [1:0]  HDR_PATTERN = 2'h1;
  localparam int          NUM_CH      = 22;
  localparam int          NUM_BIDIR   = 8;

  // ****************************************************************
  // checksum
  // ****************************************************************
  localparam logic [7:0]  CRC_POLY    = 8'h31;
  localparam logic [7:0]  CRC_INIT    = 8'h00;

  // ****************************************************************
  // register addresses
  // ****************************************************************
  localparam logic [4:0]  ADDR_NULL   = 5'h00;
  localparam logic [4:0]  ADDR_IEN    = 5'h01;
  localparam logic [4:0]  ADDR_CEN    = 5'h02;
  localparam logic [4:0]  ADDR_THR    = 5'h03;
  localparam logic [4:0]  ADDR_DIR    = 5'h04;
  localparam logic [4:0]  ADDR_SRC    = 5'h05;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [21:0] IEN_RESET   = 22'h3FFFFF;
  localparam logic [21:0] CEN_RESET   = 22'h3FFFFF;
  localparam logic [2:0]  THR_RESET   = 3'h0;
  localparam logic [7:0]  DIR_RESET   = 8'h00;
  localparam logic [2:0]  SRC_RESET   = 3'h0;

  // ****************************************************************
  // diagnostic multiplexer select range
  // ****************************************************************
  localparam logic [4:0]  DIAG_FIRST  = 5'h01;
  localparam logic [4:0]  DIAG_LAST   = 5'h16;
endpackage

// ### hw/smc_switch_monitor_spi.sv
// serial configuration, status reporting and diagnostic output of the switch monitor
module smc_switch_monitor_spi (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_sclk,
  input  wire logic        i_chip_select_n,
  input  wire logic        i_si,
  input  wire logic [21:0] i_cmp_raw,
  input  wire logic        i_sample_tick,
  input  wire logic [4:0]  i_diag_sel,
  input  wire logic        i_overtemp,
  output logic             o_so,
  output logic             o_so_oe,
  output logic             o_irq_n_pin_o,
  output logic             o_irq_n_pin_oe,
  output logic             o_diag_mux_out,
  output logic [21:0]      o_irq_enable,
  output logic [21:0]      o_cmp_enable,
  output logic [2:0]       o_thresh,
  output logic [7:0]       o_direction,
  output logic [2:0]       o_source_on,
  output logic             o_force_min_current
);
  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [2:0]  sclk_q, csn_q;
  logic [1:0]  si_q, ot_q;
  logic [21:0] cmp_m_q, cmp_s_q;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sclk_q  <= 3'h0;
      csn_q   <= 3'h7;
      si_q    <= 2'h0;
      ot_q    <= 2'h0;
      cmp_m_q <= 22'h000000;
      cmp_s_q <= 22'h000000;
    end else begin
      sclk_q  <= {sclk_q[1:0], i_sclk};
      csn_q   <= {csn_q[1:0], i_chip_select_n};
      si_q    <= {si_q[0], i_si};
      ot_q    <= {ot_q[0], i_overtemp};
      cmp_m_q <= i_cmp_raw;
      cmp_s_q <= cmp_m_q;
    end
  end

  logic sclk_rise, sclk_fall, cs_fall, cs_rise, cs_active, si_s, ot_s;
  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];
  assign cs_fall   = ~csn_q[1] & csn_q[2];
  assign cs_rise   = csn_q[1] & ~csn_q[2];
  assign cs_active = ~csn_q[1];
  assign si_s      = si_q[1];
  assign ot_s      = ot_q[1];

  // ****************************************************************
  // receive shifter and frame check
  // ****************************************************************
  logic [39:0] rx_q;
  logic [5:0]  cnt_q;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_q  <= 40'h0000000000;
      cnt_q <= 6'h00;
    end else if (cs_fall) begin
      cnt_q <= 6'h00;
    end else if (cs_active && sclk_rise) begin
      rx_q <= {rx_q[38:0], si_s};
      if (cnt_q != smc_pkg::CNT_MAX) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end
  smc_crc_if rx_crc ();
  smc_crc_if tx_crc ();
  smc_crc8 u_rx_crc (.bus(rx_crc.calc));
  smc_crc8 u_tx_crc (.bus(tx_crc.calc));
  logic       len_ok, crc_ok, frame_ok, crc_bad, is_read, do_write, do_read;
  logic [4:0] rx_addr;
  logic [23:0] rx_data;
  assign rx_crc.data = rx_q[smc_pkg::HDR_MSB:smc_pkg::DATA_LSB];
  assign crc_ok      = (rx_crc.crc == rx_q[smc_pkg::CRC_MSB:0]);
  assign len_ok      = cs_rise && (cnt_q == smc_pkg::FRAME_LEN);
  assign frame_ok    = len_ok && crc_ok &&
                       (rx_q[smc_pkg::HDR_MSB:smc_pkg::HDR_LSB] == smc_pkg::HDR_PATTERN);
  assign crc_bad     = len_ok && !crc_ok;
  assign is_read     = rx_q[smc_pkg::WR_RD_BIT];
  assign rx_addr     = rx_q[smc_pkg::ADDR_MSB:smc_pkg::ADDR_LSB];
  assign rx_data     = rx_q[smc_pkg::DATA_MSB:smc_pkg::DATA_LSB];
  assign do_write    = frame_ok && !is_read;
  assign do_read     = frame_ok && is_read && (rx_addr != smc_pkg::ADDR_NULL) &&
                       (rx_addr <= smc_pkg::ADDR_SRC);

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [21:0] ien_q, cen_q;
  logic [2:0]  thr_q, src_q;
  logic [7:0]  dir_q;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ien_q <= smc_pkg::IEN_RESET;
      cen_q <= smc_pkg::CEN_RESET;
      thr_q <= smc_pkg::THR_RESET;
      dir_q <= smc_pkg::DIR_RESET;
      src_q <= smc_pkg::SRC_RESET;
    end else if (do_write) begin
      // address zero matches no item, so the null command changes no configuration register
      unique case (rx_addr)
        smc_pkg::ADDR_IEN: ien_q <= rx_data[21:0];
        smc_pkg::ADDR_CEN: cen_q <= rx_data[21:0];
        smc_pkg::ADDR_THR: thr_q <= rx_data[23:21];
        smc_pkg::ADDR_DIR: dir_q <= rx_data[7:0];
        smc_pkg::ADDR_SRC: src_q <= rx_data[23:21];
        default: ;
      endcase
    end
  end

  assign o_irq_enable = ien_q;
  assign o_cmp_enable = cen_q;
  assign o_thresh     = thr_q;
  assign o_direction  = dir_q;
  assign o_source_on  = src_q;

  // ****************************************************************
  // switch status and change detection
  // ****************************************************************
  logic [21:0] samp_q, prev_q, status, sink_mask, changed;
  assign sink_mask = {14'h0000, dir_q};
  // comparator high means above threshold: closed for a sink, open for a source
  assign status    = cen_q & ~(samp_q ^ sink_mask);
  assign changed   = (status ^ prev_q) & ien_q & cen_q;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      samp_q <= 22'h000000;
      prev_q <= smc_pkg::CEN_RESET & ~{14'h0000, smc_pkg::DIR_RESET}; // status at reset
    end else begin
      if (i_sample_tick) begin
        samp_q <= cmp_s_q;
      end
      prev_q <= status;
    end
  end

  // ****************************************************************
  // flags and interrupt pin
  // ****************************************************************
  logic err_q, therm_q, sw_irq_q;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      err_q    <= 1'b0;
      therm_q  <= 1'b0;
      sw_irq_q <= 1'b0;
    end else begin
      if (crc_bad) begin
        err_q <= 1'b1;
      end else if (frame_ok) begin
        err_q <= 1'b0;
      end
      if (ot_s) begin
        therm_q <= 1'b1;
      end else if (frame_ok) begin
        therm_q <= 1'b0;
      end
      if (|changed) begin
        sw_irq_q <= 1'b1;
      end else if (frame_ok) begin
        sw_irq_q <= 1'b0;
      end
    end
  end

  logic irq_any;
  assign irq_any             = err_q | therm_q | sw_irq_q;
  assign o_irq_n_pin_o       = 1'b0;
  assign o_irq_n_pin_oe      = irq_any;
  assign o_force_min_current = therm_q;

  // ****************************************************************
  // read-back and transmit shifter
  // ****************************************************************
  logic        rd_pend_q;
  logic [4:0]  rd_addr_q;
  logic [23:0] rd_data, tx_data;
  logic [4:0]  tx_addr;
  logic [39:0] tx_q;

  always_comb begin
    unique case (rd_addr_q)
      smc_pkg::ADDR_IEN: rd_data = {2'h0, ien_q};
      smc_pkg::ADDR_CEN: rd_data = {2'h0, cen_q};
      smc_pkg::ADDR_THR: rd_data = {thr_q, 21'h000000};
      smc_pkg::ADDR_DIR: rd_data = {16'h0000, dir_q};
      smc_pkg::ADDR_SRC: rd_data = {src_q, 21'h000000};
      default:           rd_data = 24'h000000;
    endcase
  end

  // status is built from current settings when the select falls
  assign tx_data     = rd_pend_q ? rd_data : {2'h0, status};
  assign tx_addr     = rd_pend_q ? rd_addr_q : smc_pkg::ADDR_NULL;
  assign tx_crc.data = {err_q, therm_q, irq_any, tx_addr, tx_data};

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= 5'h00;
    end else if (do_read) begin
      rd_pend_q <= 1'b1;
      rd_addr_q <= rx_addr;
    end else if (cs_fall) begin
      rd_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_q <= 40'h0000000000;
    end else if (cs_fall) begin
      tx_q <= {tx_crc.data, tx_crc.crc};
    end else if (cs_active && sclk_fall) begin
      tx_q <= {tx_q[38:0], 1'b0};
    end
  end

  assign o_so    = tx_q[39];
  assign o_so_oe = cs_active;

  // ****************************************************************
  // diagnostic multiplexer
  // ****************************************************************
  logic       diag_q;
  logic [4:0] diag_idx;
  assign diag_idx = i_diag_sel - smc_pkg::DIAG_FIRST;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      diag_q <= 1'b0;
    end else if (i_diag_sel < smc_pkg::DIAG_FIRST || i_diag_sel > smc_pkg::DIAG_LAST) begin
      diag_q <= 1'b0;
    end else begin
      diag_q <= samp_q[diag_idx];
    end
  end
  assign o_diag_mux_out = diag_q;
  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_diag_off;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_diag_sel == 5'h00 || i_diag_sel > 5'h16) |=> (o_diag_mux_out == 1'b0);
  endproperty
  a_diag_off: assert property (p_diag_off) else $error("diag output not low");
  property p_diag_sel;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_diag_sel == 5'h09) |=> (o_diag_mux_out == $past(samp_q[8]));
  endproperty
  a_diag_sel: assert property (p_diag_sel) else $error("diag output wrong channel");
  property p_therm;
    @(posedge i_clk) disable iff (!i_reset_n)
      ot_s |=> (therm_q && o_irq_n_pin_oe && o_force_min_current);
  endproperty
  a_therm: assert property (p_therm) else $error("overtemp not flagged");
  property p_therm_clear;
    @(posedge i_clk) disable iff (!i_reset_n)
      (therm_q && !ot_s && frame_ok) |=> (!o_force_min_current);
  endproperty
  a_therm_clear: assert property (p_therm_clear) else $error("overtemp not released");
  property p_crc_bad;
    @(posedge i_clk) disable iff (!i_reset_n)
      crc_bad |=> (err_q && o_irq_n_pin_oe && $stable(ien_q) && $stable(cen_q) &&
                   $stable(thr_q) && $stable(dir_q) && $stable(src_q));
  endproperty
  a_crc_bad: assert property (p_crc_bad) else $error("bad frame not handled");
  property p_err_so;
    @(posedge i_clk) disable iff (!i_reset_n)
      (err_q && cs_fall) |=> (o_so == 1'b1);
  endproperty
  a_err_so: assert property (p_err_so) else $error("error not shown on serial out");
  property p_null;
    @(posedge i_clk) disable iff (!i_reset_n)
      (do_write && rx_addr == 5'h00) |=> ($stable(ien_q) && $stable(cen_q) &&
        $stable(thr_q) && $stable(dir_q) && $stable(src_q));
  endproperty
  a_null: assert property (p_null) else $error("null command changed a register");
  property p_ien_write;
    @(posedge i_clk) disable iff (!i_reset_n)
      (do_write && rx_addr == 5'h01) |=> (ien_q == $past(rx_q[29:8]));
  endproperty
  a_ien_write: assert property (p_ien_write) else $error("irq enable not stored");
  property p_thr_write;
    @(posedge i_clk) disable iff (!i_reset_n)
      (do_write && rx_addr == 5'h03) |=> (o_thresh == $past(rx_q[31:29]));
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("threshold not stored");
  property p_sw_irq;
    @(posedge i_clk) disable iff (!i_reset_n)
      (|changed) |=> o_irq_n_pin_oe;
  endproperty
  a_sw_irq: assert property (p_sw_irq) else $error("switch change did not interrupt");
  property p_status_off;
    @(posedge i_clk) disable iff (!i_reset_n)
      (cs_fall && !rd_pend_q && !cen_q[7]) |=> (tx_q[15] == 1'b0);
  endproperty
  a_status_off: assert property (p_status_off) else $error("disabled input reported");
  c_write: cover property (@(posedge i_clk) disable iff (!i_reset_n) do_write);
  c_read: cover property (@(posedge i_clk) disable iff (!i_reset_n) do_read ##[1:400] cs_fall);
  c_crc_bad: cover property (@(posedge i_clk) disable iff (!i_reset_n) crc_bad);
  c_therm: cover property (@(posedge i_clk) disable iff (!i_reset_n) therm_q ##1 !therm_q);
endmodule

// ### verif/smc_spi_master.sv
// serial master model that sends command frames and collects replies
module smc_spi_master (
  output logic      o_sclk,
  output logic      o_chip_select_n,
  output logic      o_si,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_sclk          = 1'b0;
    o_chip_select_n = 1'b1;
    o_si            = 1'b0;
  end

  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = smc_pkg::CRC_INIT;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? smc_pkg::CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // clock idles low between frames; data is sampled late in the high phase
  task automatic xfer(input logic [1:0] hdr, input logic wr, input logic [4:0] a,
                      input logic [23:0] d, input logic bad, input int half,
                      output logic [39:0] rep);
    logic [39:0] f;
    f = {hdr, wr, a, d, 8'h00};
    f[7:0] = crc8(f[39:8]) ^ {7'h00, bad};
    #7 o_chip_select_n = 1'b0;
    #(2 * half);
    for (int i = 39; i >= 0; i--) begin
      o_si = f[i];
      #(half) o_sclk = 1'b1;
      // an undriven serial output reads as unknown, so the reply check trips
      #(half - 10) rep[i] = i_so_oe ? i_so : 1'bx;
      #10 o_sclk = 1'b0;
    end
    #(half) o_chip_select_n = 1'b1;
    o_si = ~o_si;
    #(2 * half);
  endtask
endmodule

// ### verif/smc_switch_monitor_spi_bench.sv
// self-checking bench for the switch monitor serial configuration block
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end

module smc_switch_monitor_spi_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk, i_reset_n, sclk, cs_n, si, so, so_oe, irq_o, irq_oe, diag, force_min;
  logic        tick, otemp;
  logic [21:0] cmp, ien, cen, ien_m, cen_m, samp_m;
  logic [2:0]  thr, src, thr_m, src_m;
  logic [7:0]  dir, dir_m;
  logic [4:0]  sel;
  logic [39:0] rep;
  int          num_errors, n_checks, cycles;

  initial i_clk = 1'b0;
  always #12.5 i_clk = ~i_clk;

  smc_switch_monitor_spi i_dut (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_chip_select_n(cs_n),
    .i_si(si), .i_cmp_raw(cmp), .i_sample_tick(tick), .i_diag_sel(sel),
    .i_overtemp(otemp), .o_so(so), .o_so_oe(so_oe), .o_irq_n_pin_o(irq_o),
    .o_irq_n_pin_oe(irq_oe), .o_diag_mux_out(diag), .o_irq_enable(ien),
    .o_cmp_enable(cen), .o_thresh(thr), .o_direction(dir), .o_source_on(src),
    .o_force_min_current(force_min));

  smc_spi_master i_master (.o_sclk(sclk), .o_chip_select_n(cs_n), .o_si(si), .i_so(so),
    .i_so_oe(so_oe));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic frm(input logic [1:0] h, input logic w, input logic [4:0] a,
                     input logic [23:0] d, input logic bad, input int half);
    i_master.xfer(h, w, a, d, bad, half, rep);
    `CHK("reply crc", i_master.crc8(rep[39:8]), rep[7:0])
  endtask

  task automatic null_cmd();
    frm(2'h1, 1'b0, 5'h00, 24'hFFFFFF, 1'b0, 100);
  endtask

  task automatic chk_regs(input string nm);
    `CHK(nm, {ien_m, cen_m, thr_m, dir_m, src_m}, {ien, cen, thr, dir, src})
  endtask

  task automatic set_cmp(input logic [21:0] v);
    @(negedge i_clk) cmp = v;
    repeat (4) @(negedge i_clk);
    tick = 1'b1;
    @(negedge i_clk) tick = 1'b0;
    samp_m = v;
    repeat (4) @(negedge i_clk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    logic [23:0] wd [5] = '{24'hFD5A5A, 24'hFFFF7F, 24'hBFFFFF, 24'hFFFF0F, 24'h5FFFFF};
    logic [23:0] rd [5] = '{24'h3D5A5A, 24'h3FFF7F, 24'hA00000, 24'h00000F, 24'h400000};
    `CHK("reset regs", {44'hFFFFFFFFFFF, 14'h0000}, {ien, cen, thr, dir, src})
    for (int k = 0; k < 5; k++) begin
      frm(2'h1, 1'b0, 5'(k + 1), wd[k], 1'b0, 100);
      case (k)
        0: ien_m = wd[k][21:0];
        1: cen_m = wd[k][21:0];
        2: thr_m = wd[k][23:21];
        3: dir_m = wd[k][7:0];
        default: src_m = wd[k][23:21];
      endcase
      chk_regs("reg write");
      frm(2'h1, 1'b1, 5'(k + 1), 24'h000000, 1'b0, 100);
      null_cmd();
      `CHK("readback addr", 5'(k + 1), rep[36:32])
      `CHK("readback data", rd[k], rep[31:8])
      chk_regs("null keeps regs");
    end
    frm(2'h1, 1'b0, 5'h06, 24'hFFFFFF, 1'b0, 100);
    chk_regs("unmapped write");
    // internal sources off while comparators stay on, as for externally fed switches
    frm(2'h1, 1'b0, 5'h05, 24'h1FFFFF, 1'b0, 100);
    src_m = 3'h0;
    chk_regs("sources off");
    $display("test regs done");
  endtask

  task automatic t_status();
    set_cmp(22'h00F0F3);
    null_cmd();
    null_cmd();
    // ch0..3 sink, ch4..7 source, ch7 comparator off: closed inputs read 1
    `CHK("status", 24'h3F0F03, rep[31:8])
    `CHK("status addr", 5'h00, rep[36:32])
    `CHK("irq idle", 1'b0, irq_oe)
    set_cmp(22'h00F0F1);
    `CHK("irq enabled change", 1'b1, irq_oe)
    null_cmd();
    `CHK("irq pending bit", 1'b1, rep[37])
    null_cmd();
    set_cmp(22'h00F0F0);
    `CHK("irq masked change", 1'b0, irq_oe)
    $display("test status done");
  endtask

  task automatic t_faults();
    frm(2'h1, 1'b0, 5'h03, 24'h000000, 1'b1, 100);
    chk_regs("bad crc discarded");
    `CHK("irq on bad crc", 1'b1, irq_oe)
    null_cmd();
    `CHK("error bit", 1'b1, rep[39])
    `CHK("irq cleared", 1'b0, irq_oe)
    frm(2'h3, 1'b0, 5'h03, 24'h000000, 1'b0, 100);
    chk_regs("bad header");
    @(negedge i_clk) otemp = 1'b1;
    repeat (5) @(negedge i_clk);
    `CHK("irq overtemp", 2'h3, {irq_oe, force_min})
    null_cmd();
    `CHK("overtemp bit", 1'b1, rep[38])
    @(negedge i_clk) otemp = 1'b0;
    repeat (5) @(negedge i_clk);
    `CHK("irq held", 1'b1, irq_oe)
    null_cmd();
    `CHK("overtemp released", 2'h0, {irq_oe, force_min})
    chk_regs("regs kept");
    $display("test faults done");
  endtask

  task automatic t_diag();
    set_cmp(22'h2A5A5C);
    for (int s = 0; s < 32; s++) begin
      @(negedge i_clk) sel = 5'(s);
      repeat (3) @(negedge i_clk);
      `CHK("diag", (s >= 1 && s <= 22) ? samp_m[s - 1] : 1'b0, diag)
    end
    $display("test diag done");
  endtask

  initial begin
    {i_reset_n, tick, otemp, cmp, sel, num_errors, n_checks, cycles} = '0;
    {ien_m, cen_m, thr_m, dir_m, src_m, samp_m} = {44'hFFFFFFFFFFF, 14'h0000, 22'h000000};
    repeat (20) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (5) @(negedge i_clk);
    `CHK("reset idle", 5'h00, {irq_oe, diag, force_min, so_oe, irq_o})
    t_regs();
    t_status();
    t_faults();
    t_diag();
    tally_and_finish();
  end
endmodule
